//--- dsltc_pkg.sv
package dsltc_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SYNCW = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MEAS = 8'h0c;
  localparam logic [7:0] OFF_THR = 8'h10;
  localparam logic [7:0] OFF_CNT = 8'h14;
  localparam logic [7:0] OFF_CV = 8'h18;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] SYNCW_RST = 8'h00;
  localparam logic [31:0] MEAS_RST = 32'h0000_0000;
  localparam int CTRL_EN = 0;
  localparam int CTRL_PAM32 = 1;
  localparam int CTRL_N_LO = 8;
  localparam int OVH_SEG_DEF = 0;
  localparam int OVH_SPARE_ONE = 1;
  localparam int OVH_SPARE_TWO = 2;
  localparam logic [7:0] STUFF_OCTET = 8'h03;
  localparam int OCT11_OVF = 5;
  localparam int OCT11_RST = 6;

  // ****************************************
  // Operations channel message identifiers
  // ****************************************
  localparam logic [7:0] MSG_THR = 8'h03;
  localparam logic [7:0] MSG_STAT_REQ = 8'h0b;
  localparam logic [7:0] MSG_SNR = 8'h8b;
  localparam logic [7:0] MSG_PERF = 8'h8c;
  localparam logic [3:0] LEN_SNR = 4'h2;
  localparam logic [3:0] LEN_PERF = 4'hb;

  // ****************************************
  // Rate limits
  // ****************************************
  localparam logic [6:0] N16_MIN = 7'h03;
  localparam logic [6:0] N16_MAX = 7'h3c;
  localparam logic [6:0] N32_MIN = 7'h0c;
  localparam logic [6:0] N32_MAX = 7'h59;
  localparam logic [10:0] OCT_PER_N = 11'h00c;
  localparam logic [12:0] KBPS_PER_N = 13'h0040;

  typedef enum logic [1:0] {FR_IDLE, FR_OVH, FR_PAYLOAD, FR_STUFF}
    dsltc_fr_t;
  typedef enum logic [1:0] {EO_IDLE, EO_THR, EO_SEND} dsltc_eoc_t;

  function automatic logic rate_ok(input logic [6:0] n,
                                   input logic pam32);
    rate_ok = pam32 ? (n >= N32_MIN && n <= N32_MAX)
                    : (n >= N16_MIN && n <= N16_MAX);
  endfunction

  function automatic logic [10:0] block_octets(input logic [6:0] n);
    block_octets = OCT_PER_N * {4'h0, n};
  endfunction

  function automatic logic [12:0] rate_kbps(input logic [6:0] n);
    rate_kbps = KBPS_PER_N * {6'h00, n};
  endfunction

endpackage

//--- dsltc_ser.sv
`timescale 1ns/10ps
module dsltc_ser
  import dsltc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Octet in
  input wire logic load,
  input wire logic [7:0] octet,
  input wire logic bit_strobe,
  // Serial out
  output logic ser_bit
);

  logic [6:0] sh_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Least significant bit leaves first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sh_q <= 7'h00;
      ser_bit <= 1'b0;
    end
    else if (load)
    begin
      ser_bit <= octet[0]; // RQ19
      sh_q <= octet[7:1];
    end
    else if (bit_strobe)
    begin
      ser_bit <= sh_q[0];
      sh_q <= {1'b0, sh_q[6:1]};
    end
  end

  chk_lsb_first: assert property ( // RQ19
    load |=> ser_bit == $past(octet[0]))
    else $error("first serial bit is not octet bit 0");

endmodule

//--- dsltc_core.sv
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
// Contract
// (RQ1) Payload block is one run of 12n octets, no sub-blocks.
// (RQ2) Octet oriented only; bit parameter i is zero in all rates.
// (RQ3) Stuffing bits one and two in every frame; three, four never.
// (RQ4) Stuff indicator positions are spare bits sent as zero.
// (RQ5) Receiver picks sync word bits; transmitter sends those values.
// (RQ6) One user data channel; no four-wire, no plesiochronous mode.
// (RQ7) Office end polls remote status with message id 11.
// (RQ8) Changes other than SNR margin: answer with message id 140.
// (RQ9) Otherwise answer message id 139 with SNR margin in octet 2.
// (RQ10) Performance message octets 2 to 10 have fixed layout.
// (RQ11) Octet 11 bits 6, 7 flag counter overflow or reset.
// (RQ12) Five counters wrap freely; collector uses differences only.
// (RQ13) Thresholds come from office end in message id 3.
// (RQ14) Segment defect travels in a dedicated overhead bit.
// (RQ15) Cell status and ISDN messages are ignored.
// (RQ16) 16-level: rate is n times 64 kb/s, n 3 to 60.
// (RQ17) 32-level: rate is n times 64 kb/s, n 12 to 89.
// (RQ18) Receive synchronized shown while sync word loss bit is 0.
// (RQ19) Serial octets go least significant bit first.
// (RQ20) Reset clears counters and sets the octet 11 reset flag.
module dsltc_core
  import dsltc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Line octet timing and transmit stream
  input wire logic tx_octet_strobe,
  input wire logic tx_bit_strobe,
  output logic [7:0] tx_octet,
  output logic tx_bit,
  // User payload channel
  input wire logic pl_valid,
  input wire logic [7:0] pl_octet,
  output logic pl_take,
  // Receive status
  input wire logic rx_sync_word_loss,
  input wire logic segment_defect,
  output logic rx_synchronized_indication,
  // Performance events
  input wire logic cv_event,
  input wire logic es_event,
  input wire logic ses_event,
  input wire logic sync_word_loss_event,
  input wire logic uas_event,
  // Operations channel
  input wire logic eoc_rx_valid,
  input wire logic eoc_rx_first,
  input wire logic [7:0] eoc_rx_octet,
  input wire logic eoc_tx_ready,
  output logic eoc_tx_valid,
  output logic [7:0] eoc_tx_octet,
  output logic eoc_tx_last
);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ****************************************
  // Register bus
  // ****************************************
  logic [31:0] ctrl_q;
  logic [7:0] syncw_q;
  logic [31:0] meas_q;
  logic [7:0] thr_att_q;
  logic [7:0] thr_snr_q;
  logic wr_q;
  logic [7:0] ad_q;
  logic [31:0] rd_d;
  logic [6:0] n_rate;
  logic pam32;
  logic en;
  logic [15:0] cv_q;
  logic [7:0] es_q;
  logic [7:0] ses_q;
  logic [7:0] sync_word_loss_q;
  logic [7:0] uas_q;
  logic addr_ph;

  assign addr_ph = hsel && htrans[1] && hready;
  assign n_rate = ctrl_q[CTRL_N_LO +: 7];
  assign pam32 = ctrl_q[CTRL_PAM32];
  assign en = ctrl_q[CTRL_EN];

  always_comb
  begin
    case (haddr[7:0])
      OFF_CTRL: rd_d = ctrl_q;
      OFF_SYNCW: rd_d = {24'h000000, syncw_q};
      OFF_STATUS: rd_d = {3'h0, rate_kbps(n_rate), 13'h0000, // RQ2
                          segment_defect, rate_ok(n_rate, pam32),
                          !rx_sync_word_loss};
      OFF_MEAS: rd_d = meas_q;
      OFF_THR: rd_d = {16'h0000, thr_snr_q, thr_att_q};
      OFF_CNT: rd_d = {uas_q, sync_word_loss_q, ses_q, es_q};
      OFF_CV: rd_d = {16'h0000, cv_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      ad_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_q <= addr_ph && hwrite;
      if (addr_ph)
        ad_q <= haddr[7:0];
      if (addr_ph && !hwrite)
        hrdata <= rd_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= CTRL_RST;
      syncw_q <= SYNCW_RST;
      meas_q <= MEAS_RST;
    end
    else if (wr_q)
    begin
      case (ad_q)
        OFF_CTRL: ctrl_q <= {17'h00000, hwdata[14:8], 6'h00,
                             hwdata[1:0]};
        OFF_SYNCW: syncw_q <= hwdata[7:0]; // RQ5
        OFF_MEAS: meas_q <= {14'h0000, hwdata[17:0]};
        default: ;
      endcase
    end
  end

  // ****************************************
  // Frame builder
  // ****************************************
  dsltc_fr_t fr_q;
  logic [10:0] cnt_q;
  logic tx_load_q;
  logic go;

  assign go = en && rate_ok(n_rate, pam32); // RQ16 RQ17

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fr_q <= FR_IDLE;
      cnt_q <= 11'h000;
      tx_octet <= 8'h00;
      pl_take <= 1'b0;
      tx_load_q <= 1'b0;
    end
    else
    begin
      pl_take <= 1'b0;
      tx_load_q <= tx_octet_strobe;
      if (tx_octet_strobe)
      begin
        case (fr_q)
          FR_IDLE:
          begin
            tx_octet <= go ? syncw_q : 8'h00; // RQ5
            if (go)
              fr_q <= FR_OVH;
          end
          FR_OVH:
          begin
            tx_octet <= 8'h00;
            tx_octet[OVH_SEG_DEF] <= segment_defect; // RQ14
            tx_octet[OVH_SPARE_ONE] <= 1'b0; // RQ4
            tx_octet[OVH_SPARE_TWO] <= 1'b0; // RQ4
            cnt_q <= 11'h000;
            fr_q <= FR_PAYLOAD;
          end
          FR_PAYLOAD:
          begin
            // Single user channel, idle fill when empty
            tx_octet <= pl_valid ? pl_octet : 8'h00; // RQ6
            pl_take <= pl_valid;
            cnt_q <= cnt_q + 11'h001;
            if (cnt_q == block_octets(n_rate) - 11'h001) // RQ1
              fr_q <= FR_STUFF;
          end
          FR_STUFF:
          begin
            tx_octet <= STUFF_OCTET; // RQ3
            fr_q <= FR_IDLE;
          end
          default: fr_q <= FR_IDLE;
        endcase
      end
    end
  end

  dsltc_ser u_ser (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(tx_load_q),
    .octet(tx_octet),
    .bit_strobe(tx_bit_strobe),
    .ser_bit(tx_bit) // RQ19
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rx_synchronized_indication <= 1'b0;
    else
      rx_synchronized_indication <= !rx_sync_word_loss; // RQ18
  end

  // ****************************************
  // Performance counters
  // ****************************************
  logic ovf_q;
  logic rst_flag_q;
  logic ovf_ev;
  logic start_req;
  logic changed;
  logic [58:0] snap_q;
  logic [58:0] now_v;

  // Counters wrap; overflow noted for octet 11
  assign ovf_ev = (cv_event && cv_q == 16'hffff)
                || (es_event && es_q == 8'hff)
                || (ses_event && ses_q == 8'hff)
                || (sync_word_loss_event && sync_word_loss_q == 8'hff)
                || (uas_event && uas_q == 8'hff);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cv_q <= 16'h0000; // RQ20
      es_q <= 8'h00;
      ses_q <= 8'h00;
      sync_word_loss_q <= 8'h00;
      uas_q <= 8'h00;
    end
    else
    begin
      cv_q <= cv_q + {15'h0000, cv_event}; // RQ12
      es_q <= es_q + {7'h00, es_event};
      ses_q <= ses_q + {7'h00, ses_event};
      sync_word_loss_q <= sync_word_loss_q + {7'h00, sync_word_loss_event};
      uas_q <= uas_q + {7'h00, uas_event};
    end
  end

  // Flags clear on a sent report; a new overflow wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ovf_q <= 1'b0;
      rst_flag_q <= 1'b1; // RQ20
    end
    else
    begin
      if (ovf_ev)
        ovf_q <= 1'b1; // RQ11
      else if (start_req && changed)
        ovf_q <= 1'b0;
      if (start_req && changed)
        rst_flag_q <= 1'b0;
    end
  end

  // SNR margin left out of the comparison
  assign now_v = {cv_q, es_q, ses_q, sync_word_loss_q, uas_q, rx_sync_word_loss,
                  meas_q[17:16], meas_q[15:8]};
  assign changed = (now_v != snap_q) || ovf_q || rst_flag_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      snap_q <= '0;
    else if (start_req && changed)
      snap_q <= now_v;
  end

  // ****************************************
  // Operations channel responder
  // ****************************************
  dsltc_eoc_t eo_q;
  logic [7:0] msg_q [0:10];
  logic [3:0] len_q;
  logic [3:0] idx_q;
  logic thr_idx_q;
  logic [3:0] nxt;

  assign nxt = idx_q + 4'h1;
  // Other identifiers, cell status and ISDN among them, pass unseen
  assign start_req = eo_q == EO_IDLE && eoc_rx_valid && eoc_rx_first
                   && eoc_rx_octet == MSG_STAT_REQ; // RQ7 RQ15

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int k = 0; k < 11; k++)
        msg_q[k] <= 8'h00;
      len_q <= LEN_SNR;
    end
    else if (start_req)
    begin
      msg_q[0] <= changed ? MSG_PERF : MSG_SNR; // RQ8 RQ9
      if (changed)
      begin
        len_q <= LEN_PERF;
        msg_q[1] <= {5'h00, meas_q[17:16], rx_sync_word_loss}; // RQ10
        msg_q[2] <= meas_q[7:0];
        msg_q[3] <= meas_q[15:8];
        msg_q[4] <= es_q;
        msg_q[5] <= ses_q;
        msg_q[6] <= cv_q[15:8];
        msg_q[7] <= cv_q[7:0];
        msg_q[8] <= sync_word_loss_q;
        msg_q[9] <= uas_q;
        msg_q[10] <= 8'h00;
        msg_q[10][OCT11_OVF] <= ovf_q || ovf_ev; // RQ11
        msg_q[10][OCT11_RST] <= rst_flag_q;
      end
      else
      begin
        len_q <= LEN_SNR;
        msg_q[1] <= meas_q[7:0]; // RQ9
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      eo_q <= EO_IDLE;
      idx_q <= 4'h0;
      thr_idx_q <= 1'b0;
      thr_att_q <= 8'h00;
      thr_snr_q <= 8'h00;
      eoc_tx_valid <= 1'b0;
      eoc_tx_octet <= 8'h00;
      eoc_tx_last <= 1'b0;
    end
    else
    begin
      case (eo_q)
        EO_IDLE:
        begin
          if (start_req)
          begin
            eo_q <= EO_SEND;
            idx_q <= 4'h0;
            eoc_tx_valid <= 1'b1;
            eoc_tx_octet <= changed ? MSG_PERF : MSG_SNR;
            eoc_tx_last <= 1'b0;
          end
          else if (eoc_rx_valid && eoc_rx_first
                   && eoc_rx_octet == MSG_THR) // RQ13
          begin
            eo_q <= EO_THR;
            thr_idx_q <= 1'b0;
          end
        end
        EO_THR:
        begin
          if (eoc_rx_valid && eoc_rx_first)
            eo_q <= EO_IDLE;
          else if (eoc_rx_valid && !thr_idx_q)
          begin
            thr_att_q <= eoc_rx_octet; // RQ13
            thr_idx_q <= 1'b1;
          end
          else if (eoc_rx_valid)
          begin
            thr_snr_q <= eoc_rx_octet;
            eo_q <= EO_IDLE;
          end
        end
        EO_SEND:
        begin
          if (eoc_tx_ready && eoc_tx_last)
          begin
            eoc_tx_valid <= 1'b0;
            eoc_tx_last <= 1'b0;
            eo_q <= EO_IDLE;
          end
          else if (eoc_tx_ready)
          begin
            idx_q <= nxt;
            eoc_tx_octet <= msg_q[nxt];
            eoc_tx_last <= nxt + 4'h1 == len_q;
          end
        end
        default: eo_q <= EO_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence seq_snr_start;
    start_req && !changed ##1 eoc_tx_ready;
  endsequence

  chk_sync_follow: assert property ( // RQ18
    $past(hresetn) |->
    rx_synchronized_indication == !$past(rx_sync_word_loss))
    else $error("receive synchronized does not track loss bit");

  chk_block_end: assert property ( // RQ1
    tx_octet_strobe && fr_q == FR_PAYLOAD
    && cnt_q == block_octets(n_rate) - 11'h001 |=> fr_q == FR_STUFF)
    else $error("payload block not 12n octets long");

  chk_stuff_bits: assert property ( // RQ3
    tx_octet_strobe && fr_q == FR_STUFF |=>
    tx_octet == STUFF_OCTET && fr_q == FR_IDLE)
    else $error("stuffing octet wrong");

  chk_spare_zero: assert property ( // RQ4
    tx_octet_strobe && fr_q == FR_OVH |=>
    tx_octet[OVH_SPARE_TWO:OVH_SPARE_ONE] == 2'b00)
    else $error("spare bits not zero");

  chk_seg_defect: assert property ( // RQ14
    tx_octet_strobe && fr_q == FR_OVH |=>
    tx_octet[OVH_SEG_DEF] == $past(segment_defect))
    else $error("segment defect bit wrong");

  chk_sync_word: assert property ( // RQ5
    tx_octet_strobe && fr_q == FR_IDLE && go |=>
    tx_octet == $past(syncw_q) && fr_q == FR_OVH)
    else $error("sync word not the configured value");

  chk_rate_gate: assert property ( // RQ16 RQ17
    tx_octet_strobe && fr_q == FR_IDLE && !rate_ok(n_rate, pam32)
    |=> fr_q == FR_IDLE)
    else $error("frame started with illegal n");

  chk_perf_reply: assert property ( // RQ8
    start_req && changed |=> eoc_tx_valid && eoc_tx_octet == MSG_PERF
    && len_q == LEN_PERF)
    else $error("performance message not sent on change");

  chk_snr_reply: assert property ( // RQ9
    seq_snr_start |=> eoc_tx_last && eoc_tx_octet == msg_q[1]
    && msg_q[0] == MSG_SNR)
    else $error("short status message wrong");

  chk_reset_flag: assert property ( // RQ20
    start_req && rst_flag_q |=> msg_q[0] == MSG_PERF
    && msg_q[10][OCT11_RST])
    else $error("reset flag does not force a full report");

  chk_count_wrap: assert property ( // RQ12
    es_event && es_q == 8'hff |=> es_q == 8'h00 && ovf_q)
    else $error("errored seconds counter wrap wrong");

  chk_ovf_report: assert property ( // RQ11
    start_req && changed && ovf_q |=> msg_q[10][OCT11_OVF])
    else $error("overflow flag missing from octet 11");

endmodule

//--- dsltc_peer.sv
`timescale 1ns/10ps
module dsltc_peer
  import dsltc_pkg::*;
(
  // Clock and pace
  input wire logic hclk,
  input wire logic slow,
  // Requests to the block
  output logic eoc_rx_valid,
  output logic eoc_rx_first,
  output logic [7:0] eoc_rx_octet,
  // Replies from the block
  output logic eoc_tx_ready,
  input wire logic eoc_tx_valid,
  input wire logic [7:0] eoc_tx_octet,
  input wire logic eoc_tx_last
);
  logic [7:0] got [16];
  int cnt = 0;
  logic seen = 1'b0;

  initial
  begin
    eoc_rx_valid = 1'b0;
    eoc_rx_first = 1'b0;
    eoc_rx_octet = 8'h00;
    eoc_tx_ready = 1'b0;
  end

  // Stall every other cycle when slow
  always @(posedge hclk)
    eoc_tx_ready <= slow ? ~eoc_tx_ready : 1'b1;

  always @(posedge hclk)
    if (eoc_tx_valid && eoc_tx_ready)
    begin
      got[cnt[3:0]] <= eoc_tx_octet;
      cnt <= cnt + 1;
      seen <= eoc_tx_last;
    end

  task automatic clr();
    cnt = 0;
    seen = 1'b0;
  endtask

  // Low byte of msg goes first
  task automatic send(input logic [23:0] msg, input int len);
    for (int i = 0; i < len; i++)
    begin
      @(posedge hclk);
      eoc_rx_valid <= 1'b1;
      eoc_rx_first <= (i == 0);
      eoc_rx_octet <= msg[8*i+:8];
    end
    @(posedge hclk);
    eoc_rx_valid <= 1'b0;
    eoc_rx_first <= 1'b0;
    eoc_rx_octet <= ~eoc_rx_octet;
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top
  import dsltc_pkg::*;
();
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, slow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic tob, tbb, tx_bit, pl_valid, pl_take, loss, seg, sync_ind;
  logic [7:0] tx_octet, pl_octet, rx_oct, tx_oct;
  logic [4:0] ev;
  logic rx_valid, rx_first, tx_ready, tx_valid, tx_last;
  wire hready = hreadyout;
  int err_total = 0;
  int checked = 0;
  int takes = 0;

  always #25 hclk = ~hclk;

  dsltc_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .tx_octet_strobe(tob),
    .tx_bit_strobe(tbb), .tx_octet(tx_octet), .tx_bit(tx_bit),
    .pl_valid(pl_valid), .pl_octet(pl_octet), .pl_take(pl_take),
    .rx_sync_word_loss(loss), .segment_defect(seg),
    .rx_synchronized_indication(sync_ind), .cv_event(ev[0]),
    .es_event(ev[1]), .ses_event(ev[2]), .sync_word_loss_event(ev[3]),
    .uas_event(ev[4]), .eoc_rx_valid(rx_valid),
    .eoc_rx_first(rx_first), .eoc_rx_octet(rx_oct),
    .eoc_tx_ready(tx_ready), .eoc_tx_valid(tx_valid),
    .eoc_tx_octet(tx_oct), .eoc_tx_last(tx_last));

  dsltc_peer peer (.hclk(hclk), .slow(slow), .eoc_rx_valid(rx_valid),
    .eoc_rx_first(rx_first), .eoc_rx_octet(rx_oct),
    .eoc_tx_ready(tx_ready), .eoc_tx_valid(tx_valid),
    .eoc_tx_octet(tx_oct), .eoc_tx_last(tx_last));

  always @(posedge hclk)
    if (pl_take === 1'b1)
      takes <= takes + 1;

  // ****
  // Shared tasks
  // ****
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hr_wait();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1)
    begin
      err_total++;
      tally_and_finish();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hr_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hr_wait();
    rd = hrdata;
  endtask

  task automatic poll(input int len, input logic [7:0] id);
    int n;
    peer.clr();
    peer.send(24'h00000b, 1);
    n = 0;
    while (peer.seen !== 1'b1 && n < 200)
    begin
      @(posedge hclk);
      n++;
    end
    if (peer.seen !== 1'b1)
    begin
      err_total++;
      tally_and_finish();
    end
    chk(peer.cnt, len);
    chk({24'h0, peer.got[0]}, {24'h0, id});
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    chk({30'h0, hresp, hreadyout}, 32'h1);
    ahb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, CTRL_RST);
    ahb(1'b0, OFF_MEAS, 32'h0);
    chk(rd, MEAS_RST);
    ahb(1'b0, OFF_SYNCW, 32'h0);
    chk(rd, {24'h0, SYNCW_RST});
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, OFF_CNT, 32'hffff_ffff);
    ahb(1'b0, OFF_CNT, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, OFF_CV, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_rates();
    logic [8:0] tbl [8];
    logic [8:0] e;
    tbl = '{9'h103, 9'h002, 9'h13c, 9'h03d,
            9'h18c, 9'h08b, 9'h1d9, 9'h0da};
    for (int i = 0; i < 8; i++)
    begin
      e = tbl[i];
      ahb(1'b1, OFF_CTRL, {17'h0, e[6:0], 6'h0, e[7], 1'b1});
      ahb(1'b0, OFF_STATUS, 32'h0);
      chk(rd & (e[8] ? 32'h1fff_0002 : 32'h2),
          {3'h0, e[8] ? {e[6:0], 6'h0} : 13'h0, 14'h0, e[8], 1'b0});
    end
  endtask

  task automatic t_sync();
    for (int v = 0; v < 2; v++)
    begin
      @(posedge hclk);
      loss <= ~v[0];
      seg <= v[0];
      repeat (3) @(posedge hclk);
      #1;
      chk({31'h0, sync_ind}, {31'h0, v[0]});
      ahb(1'b0, OFF_STATUS, 32'h0);
      chk({29'h0, rd[2:0] & 3'b101}, {29'h0, v[0], 1'b0, v[0]});
    end
  endtask

  task automatic t_frame();
    logic [7:0] e;
    logic [7:0] o;
    logic [7:0] m;
    ahb(1'b1, OFF_SYNCW, 32'ha5);
    // Strobe with an illegal 32-level n: no frame may start
    @(posedge hclk);
    tob <= 1'b1;
    @(posedge hclk);
    tob <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    chk({24'h0, tx_octet}, 32'h0);
    ahb(1'b1, OFF_CTRL, 32'h0301);
    pl_valid <= 1'b1;
    pl_octet <= 8'h5a;
    takes = 0;
    for (int i = 0; i < 39; i++)
    begin
      e = i == 0 ? 8'ha5 : i == 1 ? 8'h01 : i == 38 ? STUFF_OCTET : 8'h5a;
      @(posedge hclk);
      tob <= 1'b1;
      @(posedge hclk);
      tob <= 1'b0;
      @(posedge hclk);
      #1;
      o = tx_octet;
      m = i == 1 ? 8'h07 : 8'hff;
      chk({24'h0, o & m}, {24'h0, e});
      @(posedge hclk);
      #1;
      for (int b = 0; b < 8; b++)
      begin
        chk({31'h0, tx_bit}, {31'h0, o[b]});
        if (b < 7)
        begin
          @(posedge hclk);
          tbb <= 1'b1;
          @(posedge hclk);
          tbb <= 1'b0;
          #1;
        end
      end
    end
    chk(takes, 36);
  endtask

  task automatic t_eoc();
    logic [7:0] x [10];
    x = '{8'h8c, 8'h06, 8'h12, 8'h22, 8'h01,
          8'h01, 8'h00, 8'h03, 8'h01, 8'h01};
    ahb(1'b1, OFF_MEAS, 32'h11);
    poll(11, MSG_PERF);
    chk({31'h0, peer.got[10][OCT11_RST]}, 32'h1);
    poll(2, MSG_SNR);
    chk({24'h0, peer.got[1]}, 32'h11);
    ahb(1'b1, OFF_MEAS, 32'h12);
    poll(2, MSG_SNR);
    chk({24'h0, peer.got[1]}, 32'h12);
    @(posedge hclk);
    ev <= 5'h1f;
    @(posedge hclk);
    ev <= 5'h01;
    @(posedge hclk);
    @(posedge hclk);
    ev <= 5'h00;
    ahb(1'b1, OFF_MEAS, 32'h0003_2212);
    slow <= 1'b1;
    poll(11, MSG_PERF);
    for (int i = 1; i < 10; i++)
      chk({24'h0, peer.got[i]}, {24'h0, x[i]});
    chk({31'h0, peer.got[10][OCT11_RST]}, 32'h0);
    ahb(1'b0, OFF_CNT, 32'h0);
    chk(rd, 32'h0101_0101);
    ahb(1'b0, OFF_CV, 32'h0);
    chk(rd, 32'h3);
    slow <= 1'b0;
    // Wrap the errored-second counter
    repeat (255)
    begin
      @(posedge hclk);
      ev <= 5'h02;
    end
    @(posedge hclk);
    ev <= 5'h00;
    poll(11, MSG_PERF);
    chk({24'h0, peer.got[4]}, 32'h0);
    chk({31'h0, peer.got[10][OCT11_OVF]}, 32'h1);
    peer.send(24'h554403, 3);
    ahb(1'b0, OFF_THR, 32'h0);
    chk(rd, 32'h5544);
    peer.clr();
    peer.send(24'h000011, 1);
    peer.send(24'h000094, 1);
    repeat (20) @(posedge hclk);
    chk(peer.cnt, 0);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tob = 1'b0;
    tbb = 1'b0;
    pl_valid = 1'b0;
    pl_octet = 8'h00;
    loss = 1'b0;
    seg = 1'b0;
    ev = 5'h00;
    slow = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_rates();
    t_sync();
    t_frame();
    t_eoc();
    tally_and_finish();
  end
endmodule
